// File: inc/pin_select_consts.svh
// Offsets, field positions, reset values and masks of the pin-function selector block
`ifndef PIN_SELECT_CONSTS_SVH
`define PIN_SELECT_CONSTS_SVH

// ************************************************************
// Register byte addresses
// ************************************************************
`define ADDR_BUS_GROUP_CTRL 8'h00
`define ADDR_EXT_BUS_OUT_SEL 8'h04
`define ADDR_TIMER_PIN_SEL 8'h08

// ************************************************************
// Reset values and writable masks
// ************************************************************
`define RST_BUS_GROUP_CTRL 32'h0000_0000
`define RST_EXT_BUS_OUT_SEL 32'h0000_0000
`define RST_TIMER_PIN_SEL 32'h0000_0000
`define MASK_BUS_GROUP_CTRL 32'h0000_0003
`define MASK_EXT_BUS_OUT_SEL 32'h01FF_FFFF
`define MASK_TIMER_PIN_SEL 32'h3F3C_3F3C

// ************************************************************
// Field positions
// ************************************************************
`define GRP_LOW_BIT 0
`define GRP_HIGH_BIT 1
`define EBS_ALE_BIT 0
`define EBS_CS0_BIT 1
`define EBS_ADDR_LSB 2
`define EBS_DATA_LSB 9
`define EBS_DATA_SPLIT 8
`define TPS_CH_STRIDE 8
`define TPS_A_IN_LSB 0
`define TPS_A_OUT_LSB 2
`define TPS_B_IN_LSB 4

// ************************************************************
// Sizes
// ************************************************************
`define NUM_TIMER_CH 4
`define NUM_CAND_PINS 3
`define NUM_DATA_LINES 16
`define NUM_ADDR_LINES 7

`endif

// File: inc/pin_select_pkg.sv
// Types shared by both ends of the pin-function selector
package pin_select_pkg;
    typedef logic [1:0] pin_code_t;
    typedef logic [7:0] reg_addr_t;
    typedef logic [31:0] reg_word_t;
endpackage : pin_select_pkg

// File: inc/pin_select_if.sv
// Register access channel between the selector controller and the pin selector
`timescale 1ns/1ps
interface pin_select_if;
    import pin_select_pkg::*;
    reg_addr_t addr;
    reg_word_t wdata;
    logic wr;
    logic rd;
    reg_word_t rdata;

    modport dev (
        input addr,
        input wdata,
        input wr,
        input rd,
        output rdata
    );
    modport ctl (
        output addr,
        output wdata,
        output wr,
        output rd,
        input rdata
    );
endinterface : pin_select_if

// File: hw/pin_select_dev.sv
// Pin-function selector: external bus output gating and timer ch8-11 pin routing
//
// Contract
// - Address lines 7..1 drive only when bit set
// - Chip select 0 drives only when bit1 set
// - Latch enable drives only when bit0 set
// - Reads return stored field values, no side effects
// - Group bit1 overrides data 15..8 selects
// - Group bit0 overrides address, cs0, data 7..0
// - Deep standby reset leaves selectors unchanged
// - Timer bits 31:30, 23:22 read zero
// - Timer bits 17:14 read zero
// - B input codes 00/01,10,11 pick pins 0,1,2
// - A output code 00 off, else pin 0..2
// - Odd channels have A input selector
// - All timer selectors reset to 00
// - Register covers channels 8 through 11 only
// - Nonzero A output makes A input ignored
// - Data pin input always reaches bus
`timescale 1ns/1ps
`include "pin_select_consts.svh"
module pin_select_dev
    import pin_select_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    pin_select_if.dev bus,
    // External bus controller side
    input wire logic [`NUM_ADDR_LINES-1:0] bus_addr_line,
    input wire logic bus_chip_select0,
    input wire logic bus_addr_latch_strobe,
    input wire logic [`NUM_DATA_LINES-1:0] bus_data_out,
    input wire logic [`NUM_DATA_LINES-1:0] bus_data_drive,
    output logic [`NUM_DATA_LINES-1:0] bus_data_in,
    // External bus pins
    output logic [`NUM_ADDR_LINES-1:0] addr_pin_o,
    output logic [`NUM_ADDR_LINES-1:0] addr_pin_oe,
    output logic cs0_pin_o,
    output logic cs0_pin_oe,
    output logic ale_pin_o,
    output logic ale_pin_oe,
    input wire logic [`NUM_DATA_LINES-1:0] data_pin_i,
    output logic [`NUM_DATA_LINES-1:0] data_pin_o,
    output logic [`NUM_DATA_LINES-1:0] data_pin_oe,
    // General timer channels 8..11, index 0 is channel 8
    input wire logic [`NUM_TIMER_CH-1:0] timer_a_signal_out,
    output logic [`NUM_TIMER_CH-1:0] timer_a_signal_in,
    output logic [`NUM_TIMER_CH-1:0] timer_b_signal_in,
    // Candidate pins, flattened as channel*3 + candidate
    input wire logic [`NUM_TIMER_CH*`NUM_CAND_PINS-1:0] tmr_a_pin_i,
    output logic [`NUM_TIMER_CH*`NUM_CAND_PINS-1:0] tmr_a_pin_o,
    output logic [`NUM_TIMER_CH*`NUM_CAND_PINS-1:0] tmr_a_pin_oe,
    input wire logic [`NUM_TIMER_CH*`NUM_CAND_PINS-1:0] tmr_b_pin_i,
    // Effective output enables after group override, for status
    output logic [24:0] ext_bus_eff_en
);

    // ************************************************************
    // Registers
    // ************************************************************
    // Only the system reset clears these; deep standby reset is not wired
    reg_word_t bus_group_ctrl_reg;
    reg_word_t bus_group_ctrl_next;
    reg_word_t ext_bus_output_select_reg;
    reg_word_t ext_bus_output_select_next;
    reg_word_t timer_ch8_11_pin_select_reg;
    reg_word_t timer_ch8_11_pin_select_next;
    reg_word_t rdata_reg;
    reg_word_t rdata_next;

    wire hit_grp = (bus.addr == `ADDR_BUS_GROUP_CTRL);
    wire hit_ebs = (bus.addr == `ADDR_EXT_BUS_OUT_SEL);
    wire hit_tps = (bus.addr == `ADDR_TIMER_PIN_SEL);

    // Reserved bits are masked off on store so they can never read back as one
    assign bus_group_ctrl_next = (bus.wr && hit_grp)
        ? (bus.wdata & `MASK_BUS_GROUP_CTRL) : bus_group_ctrl_reg;
    assign ext_bus_output_select_next = (bus.wr && hit_ebs)
        ? (bus.wdata & `MASK_EXT_BUS_OUT_SEL) : ext_bus_output_select_reg;
    assign timer_ch8_11_pin_select_next = (bus.wr && hit_tps)
        ? (bus.wdata & `MASK_TIMER_PIN_SEL) : timer_ch8_11_pin_select_reg;

    // ************************************************************
    // Read path
    // ************************************************************
    // Plain read of stored value; unmapped addresses read zero
    always_comb begin
        if (!bus.rd) begin
            rdata_next = 32'h0000_0000;
        end else if (hit_grp) begin
            rdata_next = bus_group_ctrl_reg;
        end else if (hit_ebs) begin
            rdata_next = ext_bus_output_select_reg;
        end else if (hit_tps) begin
            rdata_next = timer_ch8_11_pin_select_reg;
        end else begin
            rdata_next = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_group_ctrl_reg <= `RST_BUS_GROUP_CTRL;
            ext_bus_output_select_reg <= `RST_EXT_BUS_OUT_SEL;
            timer_ch8_11_pin_select_reg <= `RST_TIMER_PIN_SEL;
            rdata_reg <= 32'h0000_0000;
        end else begin
            bus_group_ctrl_reg <= bus_group_ctrl_next;
            ext_bus_output_select_reg <= ext_bus_output_select_next;
            timer_ch8_11_pin_select_reg <= timer_ch8_11_pin_select_next;
            rdata_reg <= rdata_next;
        end
    end

    assign bus.rdata = rdata_reg;

    // ************************************************************
    // External bus output gating
    // ************************************************************
    wire grp_low = bus_group_ctrl_reg[`GRP_LOW_BIT];
    wire grp_high = bus_group_ctrl_reg[`GRP_HIGH_BIT];
    wire [24:0] ebs = ext_bus_output_select_reg[24:0];

    // Group bits win over the per-line bits; ALE has no group control
    assign ext_bus_eff_en[0] = ebs[`EBS_ALE_BIT];
    assign ext_bus_eff_en[16:1] = grp_low ? 16'hFFFF : ebs[16:1];
    assign ext_bus_eff_en[24:17] = grp_high ? 8'hFF : ebs[24:17];

    assign addr_pin_o = bus_addr_line;
    assign addr_pin_oe = ext_bus_eff_en[`EBS_ADDR_LSB +: `NUM_ADDR_LINES];
    assign cs0_pin_o = bus_chip_select0;
    assign cs0_pin_oe = ext_bus_eff_en[`EBS_CS0_BIT];
    assign ale_pin_o = bus_addr_latch_strobe;
    assign ale_pin_oe = ext_bus_eff_en[`EBS_ALE_BIT];

    wire [`NUM_DATA_LINES-1:0] data_en = ext_bus_eff_en[`EBS_DATA_LSB +: `NUM_DATA_LINES];
    assign data_pin_o = bus_data_out;
    assign data_pin_oe = data_en & bus_data_drive;

    // ************************************************************
    // Pin input synchronisers
    // ************************************************************
    localparam int NP = `NUM_TIMER_CH * `NUM_CAND_PINS;
    logic [`NUM_DATA_LINES-1:0] data_s1_reg;
    logic [`NUM_DATA_LINES-1:0] data_s2_reg;
    logic [NP-1:0] a_s1_reg;
    logic [NP-1:0] a_s2_reg;
    logic [NP-1:0] b_s1_reg;
    logic [NP-1:0] b_s2_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_s1_reg <= 16'h0000;
            data_s2_reg <= 16'h0000;
            a_s1_reg <= 12'h000;
            a_s2_reg <= 12'h000;
            b_s1_reg <= 12'h000;
            b_s2_reg <= 12'h000;
        end else begin
            data_s1_reg <= data_pin_i;
            data_s2_reg <= data_s1_reg;
            a_s1_reg <= tmr_a_pin_i;
            a_s2_reg <= a_s1_reg;
            b_s1_reg <= tmr_b_pin_i;
            b_s2_reg <= b_s1_reg;
        end
    end

    // Data input is never gated by the output select bits
    assign bus_data_in = data_s2_reg;

    // ************************************************************
    // Timer channel routing, one pass per channel
    // ************************************************************
    genvar ch;
    generate
        for (ch = 0; ch < `NUM_TIMER_CH; ch++) begin : g_ch
            localparam int BASE = ch * `TPS_CH_STRIDE;
            localparam int P = ch * `NUM_CAND_PINS;
            pin_code_t b_sel;
            pin_code_t a_out_sel;
            pin_code_t a_in_sel;
            logic [2:0] b_pins;
            logic [2:0] a_pins;
            logic [2:0] a_drive;

            assign b_sel = timer_ch8_11_pin_select_reg[BASE + `TPS_B_IN_LSB +: 2];
            assign a_out_sel = timer_ch8_11_pin_select_reg[BASE + `TPS_A_OUT_LSB +: 2];
            // Stored zero on even channels, so the input path folds away there
            assign a_in_sel = timer_ch8_11_pin_select_reg[BASE + `TPS_A_IN_LSB +: 2];
            assign b_pins = b_s2_reg[P +: 3];
            assign a_pins = a_s2_reg[P +: 3];

            // Codes 00 and 01 both pick candidate 0
            assign timer_b_signal_in[ch] = (b_sel == 2'h3) ? b_pins[2]
                : (b_sel == 2'h2) ? b_pins[1] : b_pins[0];

            // One-hot drive; code 00 drives nothing
            assign a_drive[0] = (a_out_sel == 2'h1);
            assign a_drive[1] = (a_out_sel == 2'h2);
            assign a_drive[2] = (a_out_sel == 2'h3);
            assign tmr_a_pin_oe[P +: 3] = a_drive;
            assign tmr_a_pin_o[P +: 3] = a_drive & {3{timer_a_signal_out[ch]}};

            if (ch % 2 == 1) begin : g_odd
                // A pin cannot be input and output at once, so output wins
                assign timer_a_signal_in[ch] = (a_out_sel != 2'h0) ? 1'b0
                    : (a_in_sel == 2'h3) ? a_pins[2]
                    : (a_in_sel == 2'h2) ? a_pins[1] : a_pins[0];
            end else begin : g_even
                assign timer_a_signal_in[ch] = 1'b0;
            end
        end
    endgenerate

endmodule : pin_select_dev

// File: hw/pin_select_ctl.sv
// Selector controller: software port forwarded to the pin selector register channel
`timescale 1ns/1ps
`include "pin_select_consts.svh"
module pin_select_ctl
    import pin_select_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    output logic grp_low_active,
    output logic grp_high_active,
    pin_select_if.ctl bus
);

    // ************************************************************
    // Forwarding
    // ************************************************************
    // Reserved timer bits are always written as zero
    wire to_tps = (sw_addr == `ADDR_TIMER_PIN_SEL);
    wire to_grp = (sw_addr == `ADDR_BUS_GROUP_CTRL);

    assign bus.addr = sw_addr;
    assign bus.wdata = to_tps ? (sw_wdata & `MASK_TIMER_PIN_SEL) : sw_wdata;
    assign bus.wr = sw_wr;
    assign bus.rd = sw_rd;
    assign sw_rdata = bus.rdata;

    // ************************************************************
    // Group override shadow
    // ************************************************************
    // Tells software whether per-line selects are currently masked
    logic [1:0] grp_reg;
    logic [1:0] grp_next;
    assign grp_next = (sw_wr && to_grp) ? sw_wdata[1:0] : grp_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            grp_reg <= 2'h0;
        end else begin
            grp_reg <= grp_next;
        end
    end

    assign grp_low_active = grp_reg[`GRP_LOW_BIT];
    assign grp_high_active = grp_reg[`GRP_HIGH_BIT];

endmodule : pin_select_ctl

// File: verif/pin_select_monitor.sv
// Concurrent checks on the selector register channel and the pin enables
`timescale 1ns/1ps
`include "pin_select_consts.svh"
module pin_select_monitor
    import pin_select_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire reg_addr_t addr,
    input wire reg_word_t wdata,
    input wire logic wr,
    input wire logic rd,
    input wire reg_word_t rdata,
    input wire logic [6:0] addr_pin_oe,
    input wire logic cs0_pin_oe,
    input wire logic ale_pin_oe,
    input wire logic [15:0] data_pin_oe,
    input wire logic [15:0] bus_data_drive,
    input wire logic [11:0] tmr_a_pin_oe,
    input wire logic [24:0] ext_bus_eff_en,
    input wire logic grp_low_active,
    input wire logic grp_high_active
);
    // ********************
    // Assertions
    // ********************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence tps_write;
        wr && addr == `ADDR_TIMER_PIN_SEL;
    endsequence
    sequence tps_read;
        rd && addr == `ADDR_TIMER_PIN_SEL;
    endsequence
    a_rdata_idle_zero: assert property (
        !$past(rd) |-> rdata == '0) else $error("read data not zero outside read slot");
    a_timer_rsvd_zero: assert property (
        $past(rd) && $past(addr) == `ADDR_TIMER_PIN_SEL |-> (rdata & ~`MASK_TIMER_PIN_SEL) == '0)
        else $error("reserved timer bits read nonzero");
    a_timer_readback: assert property (
        tps_write ##1 tps_read |=> rdata == ($past(wdata, 2) & `MASK_TIMER_PIN_SEL))
        else $error("timer selector readback differs from write");
    a_addr_gate: assert property (
        addr_pin_oe == ext_bus_eff_en[8:2]) else $error("address drive not gated");
    a_cs0_gate: assert property (
        cs0_pin_oe == ext_bus_eff_en[1]) else $error("chip select drive not gated");
    a_ale_gate: assert property (
        ale_pin_oe == ext_bus_eff_en[0]) else $error("latch enable drive not gated");
    a_data_drive_gate: assert property (
        data_pin_oe == (ext_bus_eff_en[24:9] & bus_data_drive))
        else $error("data drive not gated");
    a_group_low_override: assert property (
        grp_low_active |-> ext_bus_eff_en[16:1] == 16'hFFFF) else $error("low group not forced");
    a_group_high_override: assert property (
        grp_high_active |-> ext_bus_eff_en[24:17] == 8'hFF) else $error("high group not forced");
    a_reset_quiet: assert property (
        $rose(rst_n) |-> tmr_a_pin_oe == '0) else $error("timer output driven after reset");
endmodule : pin_select_monitor

// File: verif/ext_pin_function_select_tb.sv
// Self-checking bench joining the selector controller and the pin selector
`timescale 1ns/1ps
`include "pin_select_consts.svh"
module ext_pin_function_select_tb;
    import pin_select_pkg::*;
    logic clk, rst_n, sw_wr, sw_rd, grp_low, grp_high, cs0_in, ale_in, cs0_oe, ale_oe;
    logic cs0_o, ale_o;
    logic [7:0] sw_addr;
    logic [31:0] sw_wdata, sw_rdata, v;
    logic [6:0] addr_line, addr_pin_o, addr_pin_oe;
    logic [15:0] data_out, data_drive, data_pin_i, data_in, data_pin_oe, data_o;
    logic [3:0] tmr_out, tmr_a_in, tmr_b_in;
    logic [11:0] tmr_a_pin_i, tmr_b_pin_i, tmr_a_pin_oe, tmr_a_o;
    logic [24:0] eff_en;
    int n_mismatch = 0;
    int total_checks = 0;
    pin_select_if sel_bus ();
    pin_select_ctl pin_select_ctl_inst (.clk(clk), .rst_n(rst_n), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
        .grp_low_active(grp_low), .grp_high_active(grp_high), .bus(sel_bus));
    pin_select_dev pin_select_dev_inst (.clk(clk), .rst_n(rst_n), .bus(sel_bus),
        .bus_addr_line(addr_line), .bus_chip_select0(cs0_in), .bus_addr_latch_strobe(ale_in),
        .bus_data_out(data_out), .bus_data_drive(data_drive), .bus_data_in(data_in),
        .addr_pin_o(addr_pin_o), .addr_pin_oe(addr_pin_oe), .cs0_pin_o(cs0_o),
        .cs0_pin_oe(cs0_oe), .ale_pin_o(ale_o), .ale_pin_oe(ale_oe), .data_pin_i(data_pin_i),
        .data_pin_o(data_o), .data_pin_oe(data_pin_oe), .timer_a_signal_out(tmr_out),
        .timer_a_signal_in(tmr_a_in), .timer_b_signal_in(tmr_b_in), .tmr_a_pin_i(tmr_a_pin_i),
        .tmr_a_pin_o(tmr_a_o), .tmr_a_pin_oe(tmr_a_pin_oe), .tmr_b_pin_i(tmr_b_pin_i),
        .ext_bus_eff_en(eff_en));
    pin_select_monitor pin_select_monitor_inst (.clk(clk), .rst_n(rst_n), .addr(sel_bus.addr),
        .wdata(sel_bus.wdata), .wr(sel_bus.wr), .rd(sel_bus.rd), .rdata(sel_bus.rdata),
        .addr_pin_oe(addr_pin_oe), .cs0_pin_oe(cs0_oe), .ale_pin_oe(ale_oe),
        .data_pin_oe(data_pin_oe), .bus_data_drive(data_drive), .tmr_a_pin_oe(tmr_a_pin_oe),
        .ext_bus_eff_en(eff_en), .grp_low_active(grp_low), .grp_high_active(grp_high));
    // ********************
    // Bench tasks
    // ********************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // One strobe per cycle; the next call keeps transfers back to back
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        sw_wr <= w;
        sw_rd <= !w;
        sw_addr <= a;
        sw_wdata <= d;
    endtask : acc
    task automatic idle();
        @(posedge clk);
        sw_wr <= 1'b0;
        sw_rd <= 1'b0;
        #1;
    endtask : idle
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        idle();
        check(sw_rdata, exp);
    endtask : rd_chk
    task automatic shake();
        @(posedge clk);
        {cs0_in, ale_in, addr_line, tmr_out} <= 13'($urandom);
        {data_out, data_drive} <= $urandom;
        data_pin_i <= 16'($urandom);
        {tmr_a_pin_i, tmr_b_pin_i} <= 24'($urandom);
    endtask : shake
    function automatic int cand(input logic [1:0] code);
        return (code < 2'h2) ? 0 : int'(code) - 1;
    endfunction : cand
    task automatic chk_ch(input int c);
        logic [7:0] f;
        logic [31:0] e;
        f = v[c*8 +: 8];
        e = (f[3:2] == 2'h0) ? 32'h0 : 32'h1 << (f[3:2] - 2'h1);
        check(32'(tmr_a_pin_oe[c*3 +: 3]), e);
        check(32'(tmr_a_o[c*3 +: 3]), e & {32{tmr_out[c]}});
        check(32'(tmr_b_in[c]), 32'(tmr_b_pin_i[c*3 + cand(f[5:4])]));
        if (c % 2 == 0)
            check(32'(tmr_a_in[c]), 32'h0);
        else if (f[3:2] == 2'h0)
            check(32'(tmr_a_in[c]), 32'(tmr_a_pin_i[c*3 + cand(f[1:0])]));
        else
            check(32'(tmr_a_in[c]), 32'h0);
    endtask : chk_ch
    // ********************
    // Main sequence
    // ********************
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h5029));
        {sw_wr, sw_rd, sw_addr, sw_wdata, cs0_in, ale_in, addr_line, tmr_out} = '0;
        {data_out, data_drive, data_pin_i, tmr_a_pin_i, tmr_b_pin_i} = '0;
        rst_n = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(`ADDR_TIMER_PIN_SEL, `RST_TIMER_PIN_SEL);
        rd_chk(`ADDR_EXT_BUS_OUT_SEL, `RST_EXT_BUS_OUT_SEL);
        rd_chk(8'h0C, 32'h0);
        // Ones written into reserved places must not stick
        acc(1'b1, `ADDR_TIMER_PIN_SEL, 32'hFFFF_FFFF);
        rd_chk(`ADDR_TIMER_PIN_SEL, `MASK_TIMER_PIN_SEL);
        acc(1'b1, `ADDR_EXT_BUS_OUT_SEL, 32'hFFFF_FFFF);
        rd_chk(`ADDR_EXT_BUS_OUT_SEL, `MASK_EXT_BUS_OUT_SEL);
        for (int i = 0; i < 24; i++) begin
            shake();
            v = $urandom & `MASK_EXT_BUS_OUT_SEL;
            acc(1'b1, `ADDR_EXT_BUS_OUT_SEL, v);
            rd_chk(`ADDR_EXT_BUS_OUT_SEL, v);
            check(32'(addr_pin_oe), 32'(v[8:2]));
            check(32'(addr_pin_o), 32'(addr_line));
            check(32'({cs0_oe, ale_oe}), 32'(v[1:0]));
            check(32'({cs0_o, ale_o}), 32'({cs0_in, ale_in}));
            check(32'(data_o), 32'(data_out));
            check(32'(data_pin_oe), 32'(v[24:9] & data_drive));
            check(32'(data_in), 32'(data_pin_i));
            v = $urandom & `MASK_TIMER_PIN_SEL;
            acc(1'b1, `ADDR_TIMER_PIN_SEL, v);
            rd_chk(`ADDR_TIMER_PIN_SEL, v);
            for (int c = 0; c < `NUM_TIMER_CH; c++)
                chk_ch(c);
        end
        acc(1'b1, `ADDR_EXT_BUS_OUT_SEL, 32'h0);
        acc(1'b1, `ADDR_BUS_GROUP_CTRL, 32'hFFFF_FFFF);
        rd_chk(`ADDR_BUS_GROUP_CTRL, 32'h3);
        check(32'(eff_en), 32'h01FF_FFFE);
        check(32'({grp_high, grp_low}), 32'h3);
        acc(1'b1, `ADDR_BUS_GROUP_CTRL, 32'h2);
        idle();
        check(32'(eff_en), 32'h01FE_0000);
        // Second reset in mid-run clears every selector again
        @(posedge clk);
        rst_n <= 1'b0;
        idle();
        rst_n <= 1'b1;
        rd_chk(`ADDR_TIMER_PIN_SEL, 32'h0);
        rd_chk(`ADDR_BUS_GROUP_CTRL, 32'h0);
        check(32'(eff_en), 32'h0);
        check(32'({grp_high, grp_low}), 32'h0);
        print_verdict();
    end
endmodule : ext_pin_function_select_tb
